/* hdl/rcpi_pkg.sv */
// Constants for the clock control and periodic interrupt block
// Summary of operation
// R1 - First control register at address 0xE, read/write, all zero after halt.
// R2 - Alarm enable bits 7 and 6 arm or disarm their alarm's match action.
// R3 - Route field steers alarm B and periodic interrupt to pin A or B.
// R4 - Host keeps test bit 3 at zero; one enters manufacturing test mode.
// R5 - Periodic select: 000 off, 001 fixed low, 01x pulse, 1xx level.
// R6 - Pulse mode toggles at 2 Hz or 1 Hz, about half duty.
// R7 - Level mode asserts each second, minute, hour or month start.
// R8 - Periodic falling edge lines up with the seconds increment.
// R9 - With slow crystal pulse halves are 0.496 s and 0.504 s.
// R10 - Trimming shifts periodic timing every 20 s by at most 3.784 ms.
// R11 - Falling edge lags the seconds increment by about 92 us.
// R12 - Second register: bits 7,6 zero; bit 4 adjust/halt; halt defaults one.
// R13 - Bit 5 selects 12-hour coding at zero, 24-hour at one.
// R14 - 12-hour coding: midnight 12, noon 32, afternoon flagged by bit 5.
// R15 - Host selects hour coding before writing any time values.
// R16 - Adjust at seconds 00-29 clears prescaler and zeroes seconds.
// R17 - Adjust at seconds 30-59 also increments minutes.
// R18 - Seconds adjustment completes within 122 us of the write.
// R19 - Adjust bit is write-only; its position reads the halt flag.
// R20 - Periodic flag reads one while output low; level-mode write zero clears.
// R21 - Alarm flag sets on match when enabled; write zero clears; disabled reads zero.
// R22 - Halt flag sets on halt, clears on write; while set clears controls.
// R23 - Clock-disable bit zero enables the crystal clock on pin B.
// R24 - Pin goes low when any routed enabled source is active.
package rcpi_pkg;
  localparam logic [3:0] ADDR_CTRL1    = 4'hE;
  localparam logic [3:0] ADDR_CTRL2    = 4'hF;
  localparam logic [7:0] CTRL1_RESET   = 8'h00;
  localparam int         BIT_ALARM_A   = 7;
  localparam int         BIT_ALARM_B   = 6;
  localparam int         BIT_ROUTE_HI  = 5;
  localparam int         BIT_ROUTE_LO  = 4;
  localparam int         BIT_TEST      = 3;
  localparam int         BIT_HOUR24    = 5;
  localparam int         BIT_ADJUST    = 4;
  localparam int         BIT_CLKDIS    = 3;
  localparam int         BIT_PFLAG     = 2;
  localparam int         BIT_AFLAG     = 1;
  localparam int         BIT_BFLAG     = 0;
  localparam logic [7:0] SEC_HALF_BCD  = 8'h30;
  localparam int         CLK_MHZ       = 50;
  localparam int         EDGE_LAG_NS   = 92000;
  localparam int         EDGE_LAG_CYC  = EDGE_LAG_NS * CLK_MHZ / 1000;
  localparam int         ADJ_MAX_NS    = 122000;
  localparam int         ADJ_MAX_CYC   = ADJ_MAX_NS * CLK_MHZ / 1000;
  localparam int         TRIM_PERIOD_S = 20;
  // Periodic select codes
  localparam logic [2:0] PSEL_OFF      = 3'h0;
  localparam logic [2:0] PSEL_LOW      = 3'h1;
  localparam logic [2:0] PSEL_2HZ      = 3'h2;
  localparam logic [2:0] PSEL_1HZ      = 3'h3;
  localparam logic [2:0] PSEL_SEC      = 3'h4;
  localparam logic [2:0] PSEL_MIN      = 3'h5;
  localparam logic [2:0] PSEL_HOUR     = 3'h6;
  localparam logic [2:0] PSEL_MONTH    = 3'h7;
endpackage : rcpi_pkg

/* hdl/rcpi_ctrl.sv */
// Control registers, output routing and periodic interrupt timing
`timescale 1ns/1ps
`default_nettype none
module rcpi_ctrl #(
  parameter int LAG_CYCLES = rcpi_pkg::EDGE_LAG_CYC
) (
  input  wire logic       clk_in,            // 50 MHz system clock
  input  wire logic       reset_in,          // Async reset, active high
  input  wire logic [3:0] reg_addr_in,       // Internal register address
  input  wire logic [7:0] reg_wdata_in,      // Write data
  input  wire logic       reg_wr_in,         // Write strobe, one cycle
  input  wire logic       reg_rd_in,         // Read strobe, one cycle
  input  wire logic       sec_tick_in,       // Seconds counter increments
  input  wire logic       quarter_tick_in,   // Prescaler quarter, not at second
  input  wire logic [7:0] seconds_bcd_in,    // Current seconds, BCD
  input  wire logic       at_sec00_in,       // New seconds value is 00
  input  wire logic       at_min00_in,       // New time is mm:ss 00:00
  input  wire logic       at_month1_in,      // New time is day 1 00:00:00
  input  wire logic       alarm_a_match_in,  // Alarm A compare hit, pulse
  input  wire logic       alarm_b_match_in,  // Alarm B compare hit, pulse
  input  wire logic       osc_halt_in,       // Oscillator halt detector, async
  input  wire logic       clk32k_in,         // Crystal clock, async
  output logic      [7:0] reg_rdata_out,     // Read data, valid after strobe
  output logic            irq_pin_a_n_out,   // Pin A level, low when active
  output logic            irq_pin_a_oe_out,  // Pin A drive enable
  output logic            irq_pin_b_n_out,   // Pin B level, low when active
  output logic            irq_pin_b_oe_out,  // Pin B drive enable
  output logic            presc_clear_out,   // Clear sub-second stages, pulse
  output logic            seconds_zero_out,  // Load seconds with 00, pulse
  output logic            minute_inc_out,    // Increment minutes, pulse
  output logic            hour24_out,        // 24-hour coding selected
  output logic            test_mode_out      // Manufacturing test mode
);

  localparam int LW = $clog2(LAG_CYCLES + 1);

  typedef struct packed {
    logic [7:0]    ctrl1;
    logic          hour24;
    logic          halt;
    logic          clkdis;
    logic          pflag;
    logic          aflag;
    logic          bflag;
    logic [LW-1:0] lag;
    logic [1:0]    quarter;
    logic          halt_s1;
    logic          halt_s2;
    logic          clk_s1;
    logic          clk_s2;
    logic [7:0]    rdata;
    logic          pin_a;
    logic          pin_a_oe;
    logic          pin_b;
    logic          pin_b_oe;
    logic          presc_clr;
    logic          sec_zero;
    logic          min_inc;
  } rcpi_state_s;

  rcpi_state_s st;
  rcpi_state_s next_st;

  logic       wr_c1;
  logic       wr_c2;
  logic       sec_edge;
  logic [2:0] psel;
  logic       level_mode;
  logic       level_hit;
  logic       a_on;
  logic       b_on;
  logic       route_b_alarm;
  logic       route_b_per;

  // Decode of strobes and current settings
  always_comb begin
    wr_c1 = reg_wr_in && (reg_addr_in == rcpi_pkg::ADDR_CTRL1);
    wr_c2 = reg_wr_in && (reg_addr_in == rcpi_pkg::ADDR_CTRL2);
    sec_edge = (st.lag == LW'(1));                                 // R8 R11
    psel = st.ctrl1[2:0];
    level_mode = psel[2];                                          // R5
    route_b_alarm = st.ctrl1[rcpi_pkg::BIT_ROUTE_LO];              // R3
    route_b_per = st.ctrl1[rcpi_pkg::BIT_ROUTE_HI];                // R3
    case (psel)                                                    // R7
      rcpi_pkg::PSEL_SEC:   level_hit = 1'b1;
      rcpi_pkg::PSEL_MIN:   level_hit = at_sec00_in;
      rcpi_pkg::PSEL_HOUR:  level_hit = at_min00_in;
      rcpi_pkg::PSEL_MONTH: level_hit = at_month1_in;
      default:              level_hit = 1'b0;
    endcase
  end

  // Next state of the whole block
  always_comb begin
    next_st = st;
    next_st.halt_s1 = osc_halt_in;
    next_st.halt_s2 = st.halt_s1;
    next_st.clk_s1 = clk32k_in;
    next_st.clk_s2 = st.clk_s1;
    next_st.presc_clr = 1'b0;
    next_st.sec_zero = 1'b0;
    next_st.min_inc = 1'b0;
    // Seconds increment delayed to the output edge
    if (sec_tick_in) begin
      next_st.lag = LW'(LAG_CYCLES);                               // R11
    end else if (st.lag != '0) begin
      next_st.lag = st.lag - LW'(1);
    end
    // Quarter-second phase, restarted by the delayed second edge
    if (sec_edge) begin
      next_st.quarter = 2'h0;                                      // R8
    end else if (quarter_tick_in) begin
      next_st.quarter = st.quarter + 2'h1;                         // R9 R10
    end
    // First control register
    if (wr_c1) begin
      next_st.ctrl1 = reg_wdata_in;                                // R1 R2 R4
    end
    // Second control register writes
    if (wr_c2) begin
      next_st.hour24 = reg_wdata_in[rcpi_pkg::BIT_HOUR24];         // R13 R14
      next_st.clkdis = reg_wdata_in[rcpi_pkg::BIT_CLKDIS];         // R23
      next_st.halt = 1'b0;                                         // R22
      if (reg_wdata_in[rcpi_pkg::BIT_ADJUST]) begin
        next_st.presc_clr = 1'b1;                                  // R16 R18
        next_st.sec_zero = 1'b1;                                   // R16
        next_st.min_inc = (seconds_bcd_in >= rcpi_pkg::SEC_HALF_BCD); // R17
      end
      if (!reg_wdata_in[rcpi_pkg::BIT_AFLAG]) begin
        next_st.aflag = 1'b0;                                      // R21
      end
      if (!reg_wdata_in[rcpi_pkg::BIT_BFLAG]) begin
        next_st.bflag = 1'b0;                                      // R21
      end
      if (!reg_wdata_in[rcpi_pkg::BIT_PFLAG] && level_mode) begin
        next_st.pflag = 1'b0;                                      // R20
      end
    end
    // Alarm matches; set wins over a clear in the same cycle
    if (alarm_a_match_in && st.ctrl1[rcpi_pkg::BIT_ALARM_A]) begin
      next_st.aflag = 1'b1;                                        // R2 R21
    end
    if (alarm_b_match_in && st.ctrl1[rcpi_pkg::BIT_ALARM_B]) begin
      next_st.bflag = 1'b1;                                        // R2 R21
    end
    // Periodic flag by select code
    case (psel)
      rcpi_pkg::PSEL_OFF: next_st.pflag = 1'b0;                    // R5
      rcpi_pkg::PSEL_LOW: next_st.pflag = 1'b1;                    // R5
      rcpi_pkg::PSEL_2HZ: next_st.pflag = ~next_st.quarter[0];     // R6 R9
      rcpi_pkg::PSEL_1HZ: next_st.pflag = ~next_st.quarter[1];     // R6 R9
      default: begin
        if (sec_edge && level_hit) begin
          next_st.pflag = 1'b1;                                    // R7 R8
        end
      end
    endcase
    // Halt event forces defaults and holds them while flagged
    if (st.halt_s2) begin
      next_st.halt = 1'b1;                                         // R22
    end
    if (next_st.halt) begin
      next_st.ctrl1 = rcpi_pkg::CTRL1_RESET;                       // R1 R22
      next_st.clkdis = 1'b0;                                       // R22 R23
      next_st.pflag = 1'b0;                                        // R12
      next_st.aflag = 1'b0;                                        // R12
      next_st.bflag = 1'b0;                                        // R12
    end
    // Disabled alarms read zero
    if (!next_st.ctrl1[rcpi_pkg::BIT_ALARM_A]) begin
      next_st.aflag = 1'b0;                                        // R21
    end
    if (!next_st.ctrl1[rcpi_pkg::BIT_ALARM_B]) begin
      next_st.bflag = 1'b0;                                        // R21
    end
    // Register read path
    if (reg_rd_in) begin
      if (reg_addr_in == rcpi_pkg::ADDR_CTRL1) begin
        next_st.rdata = st.ctrl1;                                  // R1
      end else if (reg_addr_in == rcpi_pkg::ADDR_CTRL2) begin
        next_st.rdata = {2'b00, st.hour24, st.halt, st.clkdis,
                         st.pflag, st.aflag, st.bflag};            // R12 R19
      end else begin
        next_st.rdata = 8'h00;
      end
    end
    // Pin routing; pin B also carries the crystal clock
    a_on = st.aflag || (st.bflag && !route_b_alarm) || (st.pflag && !route_b_per);
    b_on = (st.bflag && route_b_alarm) || (st.pflag && route_b_per);
    next_st.pin_a = ~a_on;                                         // R3 R24
    next_st.pin_b = ~b_on && (st.clkdis || st.clk_s2);             // R3 R23 R24
    // Drive enables kept in their own flops
    next_st.pin_a_oe = a_on;                                       // R24
    next_st.pin_b_oe = ~next_st.pin_b;                             // R24
  end

  // State register
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      st <= '0;
      st.halt <= 1'b1;
      st.pin_a <= 1'b1;
      st.pin_b <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state
  assign reg_rdata_out = st.rdata;
  assign irq_pin_a_n_out = st.pin_a;
  assign irq_pin_a_oe_out = st.pin_a_oe;
  assign irq_pin_b_n_out = st.pin_b;
  assign irq_pin_b_oe_out = st.pin_b_oe;
  assign presc_clear_out = st.presc_clr;
  assign seconds_zero_out = st.sec_zero;
  assign minute_inc_out = st.min_inc;
  assign hour24_out = st.hour24;
  assign test_mode_out = st.ctrl1[rcpi_pkg::BIT_TEST];             // R4

  // Checks on the control behaviour
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  sequence s_adj_write;
    wr_c2 && reg_wdata_in[rcpi_pkg::BIT_ADJUST];
  endsequence

  sequence s_level_clear;
    wr_c2 && !reg_wdata_in[rcpi_pkg::BIT_PFLAG] && level_mode && !sec_edge;
  endsequence

  // Plain first-register write with no halt in the way
  sequence s_c1_write;
    wr_c1 && !st.halt && !st.halt_s2;
  endsequence

  // Level mode flag with nothing that may move it
  sequence s_level_quiet;
    level_mode && st.pflag && !wr_c1 && !wr_c2 && !st.halt_s2;
  endsequence

  a_halt_clears_c1: assert property (st.halt |-> st.ctrl1 == 8'h00 && !st.clkdis) // R22
    else $error("controls not cleared during halt");
  a_alarm_a_sets: assert property (                                 // R21
    alarm_a_match_in && st.ctrl1[7] && !st.halt && !st.halt_s2 && !wr_c1 |=> st.aflag)
    else $error("alarm A flag not set on match");
  a_alarm_off_zero: assert property (st.aflag |-> st.ctrl1[7])      // R2
    else $error("disabled alarm flag reads one");
  a_route_pin_a: assert property (                                  // R24
    st.pflag && !st.ctrl1[5] |=> !irq_pin_a_n_out && irq_pin_a_oe_out)
    else $error("periodic not driven on pin A");
  a_route_pin_b: assert property (                                  // R3
    st.bflag && st.ctrl1[4] |=> !irq_pin_b_n_out)
    else $error("alarm B not driven on pin B");
  a_adj_early: assert property (                                    // R16
    s_adj_write ##0 seconds_bcd_in < 8'h30 |=> presc_clear_out && seconds_zero_out && !minute_inc_out)
    else $error("early adjust wrong");
  a_adj_late: assert property (                                     // R17
    s_adj_write ##0 seconds_bcd_in >= 8'h30 |=> minute_inc_out ##1 !minute_inc_out)
    else $error("late adjust wrong");
  a_level_release: assert property (                                // R20
    s_level_clear ##0 !st.halt_s2 ##0 psel[2] |=> !st.pflag)
    else $error("level flag not released");
  a_fixed_low: assert property (                                    // R5
    psel == 3'h1 && !st.halt && !st.halt_s2 && !wr_c1 |=> st.pflag [*1])
    else $error("fixed low mode not low");
  a_read_c2: assert property (                                      // R12 R19
    reg_rd_in && reg_addr_in == 4'hF |=> reg_rdata_out[7:6] == 2'b00
    && reg_rdata_out[4] == $past(st.halt))
    else $error("second register read wrong");
  a_level_edge: assert property (                                   // R8
    psel == 3'h4 && $past(psel) == 3'h4 && $rose(st.pflag) |-> $past(sec_edge))
    else $error("level assert off the second edge");

  // Halt flag capture and release
  a_halt_sets: assert property (st.halt_s2 |=> st.halt)             // R22
    else $error("halt flag not set");
  a_halt_release: assert property (wr_c2 && !st.halt_s2 |=> !st.halt) // R22
    else $error("halt flag not cleared by write");
  a_halt_flags: assert property (                                   // R12
    st.halt |-> !st.pflag && !st.aflag && !st.bflag)
    else $error("flags set during halt");

  // Register file access
  a_c1_write: assert property (                                     // R1
    s_c1_write |=> st.ctrl1 == $past(reg_wdata_in))
    else $error("first register write lost");
  a_c1_read: assert property (                                      // R1
    reg_rd_in && reg_addr_in == 4'hE |=> reg_rdata_out == $past(st.ctrl1))
    else $error("first register read wrong");
  a_unmapped_read: assert property (                                // R1
    reg_rd_in && reg_addr_in < 4'hE |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  a_read_hold: assert property (!reg_rd_in |=> $stable(reg_rdata_out)) // R12
    else $error("read data moved without a read");
  a_hour_write: assert property (                                   // R13
    wr_c2 |=> hour24_out == $past(reg_wdata_in[5]))
    else $error("hour coding bit not written");
  a_adj_none: assert property (                                     // R16
    wr_c2 && !reg_wdata_in[4] |=> !presc_clear_out && !seconds_zero_out)
    else $error("adjust without adjust bit");

  // Alarm flags
  a_alarm_b_sets: assert property (                                 // R21
    alarm_b_match_in && st.ctrl1[6] && !st.halt && !st.halt_s2 && !wr_c1 |=> st.bflag)
    else $error("alarm B flag not set on match");
  a_alarm_clr: assert property (                                    // R21
    wr_c2 && !reg_wdata_in[1] && !alarm_a_match_in |=> !st.aflag)
    else $error("alarm A flag not cleared");
  a_alarm_b_zero: assert property (st.bflag |-> st.ctrl1[6])        // R2
    else $error("disabled alarm B flag reads one");

  // Periodic flag by mode
  a_off_inactive: assert property (                                 // R5
    psel == 3'h0 && !wr_c1 |=> !st.pflag)
    else $error("off mode flag set");
  a_flag_one_noop: assert property (                                // R20
    wr_c2 && reg_wdata_in[2] && !st.pflag && level_mode && !sec_edge && !wr_c1 |=> !st.pflag)
    else $error("writing one set the flag");
  a_level_hold: assert property (s_level_quiet |=> st.pflag)        // R20
    else $error("level flag dropped by itself");
  a_pulse_edge: assert property (                                   // R6 R8
    psel == 3'h2 && sec_edge && !wr_c1 && !st.halt_s2 |=> st.pflag)
    else $error("pulse not low at second edge");
  a_lag_load: assert property (sec_tick_in |=> !sec_edge)           // R11
    else $error("second edge not delayed");

  // Pin levels and drive enables
  a_pin_a_alarm: assert property (st.aflag |=> !irq_pin_a_n_out)    // R24
    else $error("alarm A not on pin A");
  a_pin_a_idle: assert property (                                   // R24
    !st.aflag && !st.bflag && !st.pflag |=> irq_pin_a_n_out)
    else $error("pin A low with no source");
  a_clk_gated: assert property (                                    // R23
    st.clkdis && !st.pflag && !st.bflag |=> irq_pin_b_n_out)
    else $error("pin B clock not gated");
  a_clk_passes: assert property (                                   // R23
    !st.clkdis && !st.pflag && !st.bflag |=> irq_pin_b_n_out == $past(st.clk_s2))
    else $error("pin B clock not passed");
  a_oe_pin_a: assert property (irq_pin_a_oe_out == !irq_pin_a_n_out) // R3
    else $error("pin A enable mismatch");
  a_oe_pin_b: assert property (irq_pin_b_oe_out == !irq_pin_b_n_out) // R3
    else $error("pin B enable mismatch");

endmodule : rcpi_ctrl
`default_nettype wire

/* tb/rcpi_time_model.sv */
// Timekeeping side model: second and quarter ticks, time levels, alarms, crystal
`timescale 1ns/1ps
`default_nettype none
module rcpi_time_model (
  input  wire logic       clk_in,       // System clock
  output logic            sec_tick_out, // Seconds increment pulse
  output logic            qtr_tick_out, // Quarter point pulse
  output logic      [7:0] sec_bcd_out,  // Seconds value, BCD
  output logic            at_zero_out,  // Time at second 00
  output logic            at_min_out,   // Time at minute 00 second 00
  output logic            at_month_out, // Time at month start
  output logic            alarm_a_out,  // Alarm A hit pulse
  output logic            alarm_b_out,  // Alarm B hit pulse
  output logic            halt_out,     // Oscillator halt level
  output logic            xtal_out      // Crystal clock, runs free
);
  // Idle levels, then a free running crystal
  initial begin
    {sec_tick_out, qtr_tick_out, alarm_a_out, alarm_b_out, halt_out, at_zero_out, xtal_out} = '0;
    sec_bcd_out = 8'h00;
    {at_min_out, at_month_out} = 2'h0;
    forever #70 xtal_out = ~xtal_out;
  end
  // One-cycle pulse on a chosen line, launched off the sampling edge
  task automatic pulse(input int sel);
    @(negedge clk_in);
    case (sel)
      0: sec_tick_out = 1'b1;
      1: qtr_tick_out = 1'b1;
      2: alarm_a_out = 1'b1;
      default: alarm_b_out = 1'b1;
    endcase
    @(negedge clk_in);
    {sec_tick_out, qtr_tick_out, alarm_a_out, alarm_b_out} = '0;
  endtask : pulse
endmodule : rcpi_time_model
`default_nettype wire

/* tb/tb.sv */
// Testbench for the control registers and periodic interrupt block
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int LAG = 8;
  logic       clk_in, reset_in, wr_s, rd_s, pa, pa_oe, pb, pb_oe, pclr, szero, minc, h24, tmode;
  logic       stick, qtick, azero, amin, amon, ama, amb, halt, xtal;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, secs;
  logic [2:0] seen;
  int         mismatches, n_checks, n, c;
  rcpi_time_model m (.clk_in(clk_in), .sec_tick_out(stick), .qtr_tick_out(qtick), .sec_bcd_out(secs),
    .at_zero_out(azero), .at_min_out(amin), .at_month_out(amon), .alarm_a_out(ama), .alarm_b_out(amb),
    .halt_out(halt), .xtal_out(xtal));
  rcpi_ctrl #(.LAG_CYCLES(LAG)) uut (.clk_in(clk_in), .reset_in(reset_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s), .sec_tick_in(stick), .quarter_tick_in(qtick),
    .seconds_bcd_in(secs), .at_sec00_in(azero), .at_min00_in(amin), .at_month1_in(amon),
    .alarm_a_match_in(ama), .alarm_b_match_in(amb), .osc_halt_in(halt), .clk32k_in(xtal),
    .reg_rdata_out(rdata), .irq_pin_a_n_out(pa), .irq_pin_a_oe_out(pa_oe), .irq_pin_b_n_out(pb),
    .irq_pin_b_oe_out(pb_oe), .presc_clear_out(pclr), .seconds_zero_out(szero), .minute_inc_out(minc),
    .hour24_out(h24), .test_mode_out(tmode));
  // Clock
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  // Sticky record of adjust pulses
  always @(posedge clk_in) seen <= seen | {pclr, szero, minc};
  task automatic summarize;
    if (mismatches == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask : chk1
  task automatic wait_n(input int k);
    repeat (k) @(negedge clk_in);
  endtask : wait_n
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr = a;
    wdata = d;
    wr_s = 1'b1;
    @(negedge clk_in);
    wr_s = 1'b0;
    wait_n(2);
  endtask : wr
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    @(negedge clk_in);
    addr = a;
    rd_s = 1'b1;
    @(negedge clk_in);
    rd_s = 1'b0;
    @(negedge clk_in);
    chk8(rdata, e);
  endtask : rdc
  task automatic sec_ev;
    m.pulse(0);
    wait_n(LAG + 4);
  endtask : sec_ev
  // Counts pin B changes over a stretch
  task automatic cnt_b(output int k);
    logic prev;
    k = 0;
    prev = pb;
    repeat (60) begin
      @(negedge clk_in);
      k += int'(pb !== prev);
      prev = pb;
    end
  endtask : cnt_b
  // Hang guard
  initial begin
    #1500000;
    mismatches++;
    summarize();
  end
  // Main sequence
  initial begin
    reset_in = 1'b1;
    {wr_s, rd_s, addr, wdata, seen} = '0;
    mismatches = 0;
    n_checks = 0;
    repeat (16) @(posedge clk_in);
    @(negedge clk_in);
    reset_in = 1'b0;
    rdc(rcpi_pkg::ADDR_CTRL2, 8'h10);
    wr(rcpi_pkg::ADDR_CTRL1, 8'hC0);
    rdc(rcpi_pkg::ADDR_CTRL1, 8'h00);
    wr(rcpi_pkg::ADDR_CTRL2, 8'h28);
    rdc(rcpi_pkg::ADDR_CTRL2, 8'h28);
    chk1(h24, 1'b1);
    wr(rcpi_pkg::ADDR_CTRL1, 8'hF7);
    rdc(rcpi_pkg::ADDR_CTRL1, 8'hF7);
    chk1(tmode, 1'b0);
    rdc(4'h3, 8'h00);
    // Adjust below and above the half minute
    for (c = 0; c < 2; c++) begin
      m.sec_bcd_out = c ? 8'h45 : 8'h12;
      seen = 3'h0;
      wr(rcpi_pkg::ADDR_CTRL2, 8'h38);
      chk8({5'h00, seen}, c ? 8'h07 : 8'h06);
      rdc(rcpi_pkg::ADDR_CTRL2, 8'h28);
    end
    // Periodic source on each route, cleared by a zero write
    for (c = 0; c < 4; c++) begin
      wr(rcpi_pkg::ADDR_CTRL1, {2'b00, c[1:0], 1'b0, rcpi_pkg::PSEL_SEC});
      sec_ev();
      chk1(pa, c[1]);
      chk1(pb, ~c[1]);
      rdc(rcpi_pkg::ADDR_CTRL2, 8'h2C);
      wr(rcpi_pkg::ADDR_CTRL2, 8'h28);
      chk1(pa & pb, 1'b1);
    end
    // Level codes, first off the boundary (code 4 has no off case), then on it
    for (c = 4; c < 8; c++) begin
      wr(rcpi_pkg::ADDR_CTRL1, 8'(c));
      {m.at_zero_out, m.at_min_out, m.at_month_out} = {c != 5, c != 6, c != 7};
      m.pulse(0);
      wait_n(LAG - 3);
      chk1(pa, 1'b1);
      wait_n(7);
      chk1(pa, c != 4);
      {m.at_zero_out, m.at_min_out, m.at_month_out} = {c == 5, c == 6, c == 7};
      sec_ev();
      chk1(pa, 1'b0);
      wr(rcpi_pkg::ADDR_CTRL2, 8'h28);
    end
    // Pulse codes follow the quarter phase
    for (c = 2; c < 4; c++) begin
      wr(rcpi_pkg::ADDR_CTRL1, 8'(c));
      sec_ev();
      chk1(pa, 1'b0);
      m.pulse(1);
      wait_n(3);
      chk1(pa, c == 2);
      m.pulse(1);
      wait_n(3);
      chk1(pa, c == 3);
    end
    wr(rcpi_pkg::ADDR_CTRL1, {5'h00, rcpi_pkg::PSEL_LOW});
    chk1(pa, 1'b0);
    wr(rcpi_pkg::ADDR_CTRL1, {5'h00, rcpi_pkg::PSEL_OFF});
    wr(rcpi_pkg::ADDR_CTRL2, 8'h28);
    chk1(pa, 1'b1);
    // Alarms: A armed, B disarmed then armed on pin B
    wr(rcpi_pkg::ADDR_CTRL1, 8'h90);
    m.pulse(2);
    m.pulse(3);
    wait_n(3);
    rdc(rcpi_pkg::ADDR_CTRL2, 8'h2A);
    chk1(pa, 1'b0);
    chk1(pb, 1'b1);
    wr(rcpi_pkg::ADDR_CTRL2, 8'h28);
    chk1(pa, 1'b1);
    wr(rcpi_pkg::ADDR_CTRL1, 8'hD0);
    m.pulse(3);
    wait_n(3);
    chk1(pb, 1'b0);
    chk1(pa, 1'b1);
    // Crystal clock on pin B, then gated
    wr(rcpi_pkg::ADDR_CTRL1, 8'h00);
    wr(rcpi_pkg::ADDR_CTRL2, 8'h20);
    cnt_b(n);
    chk1(n > 2, 1'b1);
    wr(rcpi_pkg::ADDR_CTRL2, 8'h28);
    cnt_b(n);
    chk8(8'(n), 8'h00);
    // Oscillator halt clears the controls and sets the flag
    wr(rcpi_pkg::ADDR_CTRL1, 8'hF7);
    m.halt_out = 1'b1;
    wait_n(5);
    m.halt_out = 1'b0;
    wait_n(5);
    rdc(rcpi_pkg::ADDR_CTRL1, 8'h00);
    rdc(rcpi_pkg::ADDR_CTRL2, 8'h30);
    summarize();
  end
endmodule : tb
`default_nettype wire
